// ---- common/usb_port_params.svh ----
`ifndef USB_PORT_PARAMS_SVH
`define USB_PORT_PARAMS_SVH

// ------------------------------------------------------------
// Register offsets (byte addresses)
// ------------------------------------------------------------
`define OFF_CHAN_SUMMARY 12'h414
`define OFF_CHAN_MASK 12'h418
`define OFF_PORT_CS 12'h440
`define OFF_CHAN_FLAGS 12'h450

// ------------------------------------------------------------
// Port control/status field positions
// ------------------------------------------------------------
`define PCS_CONNECT_STATE 0
`define PCS_CONNECT_EVENT 1
`define PCS_LINK_ENABLED 2
`define PCS_ENABLE_CHANGE 3
`define PCS_RESUME 6
`define PCS_SLEEP 7
`define PCS_BUS_RESET 8
`define PCS_LINE_LO 10
`define PCS_LINE_HI 11
`define PCS_POWER 12
`define PCS_RATE_LO 17
`define PCS_RATE_HI 18

// ------------------------------------------------------------
// Reset values and sizes
// ------------------------------------------------------------
`define CHAN_MASK_RESET 8'h00
`define PORT_CS_RESET 32'h0000_0000
`define NUM_CHANNELS 8
`define FLAGS_PER_CHAN 4

`endif

// ---- common/usb_port_pkg.sv ----
package usb_port_pkg;

    typedef enum logic [1:0] {
        RATE_NONE = 2'h0,
        RATE_FULL = 2'h1,
        RATE_LOW = 2'h2
    } device_rate_code_t;

    typedef enum {
        PORT_IDLE,
        PORT_RESETTING,
        PORT_ACTIVE
    } port_state_t;

endpackage : usb_port_pkg

// ---- hw/chan_flag_cell.sv ----
`timescale 1ns/1ps
`include "usb_port_params.svh"

// One channel's set-by-hardware, write-one-to-clear flags
module chan_flag_cell (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Events and clears
    input wire logic [`FLAGS_PER_CHAN-1:0] set_in,
    input wire logic [`FLAGS_PER_CHAN-1:0] clear_in,
    // State
    output logic [`FLAGS_PER_CHAN-1:0] flags_out,
    output logic pending_out
);
    logic [`FLAGS_PER_CHAN-1:0] flags_q;
    logic [`FLAGS_PER_CHAN-1:0] flags_d;

    // Set wins over a clear in the same cycle
    assign flags_d = set_in | (flags_q & ~clear_in);

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            flags_q <= '0;
        end else begin
            flags_q <= flags_d;
        end
    end

    assign flags_out = flags_q;
    assign pending_out = |flags_q;
endmodule : chan_flag_cell

// ---- hw/line_sampler.sv ----
`timescale 1ns/1ps

// Two-stage sampler for the bus line and attach levels
module line_sampler (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Raw levels
    input wire logic [2:0] raw_in,
    // Synchronised levels
    output logic [2:0] sync_out
);
    logic [2:0] stage1_q;
    logic [2:0] stage2_q;

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            stage1_q <= 3'h0;
            stage2_q <= 3'h0;
        end else begin
            stage1_q <= raw_in;
            stage2_q <= stage1_q;
        end
    end

    assign sync_out = stage2_q;
endmodule : line_sampler

// ---- hw/usb_host_port.sv ----
// Contract
// - Summary has one bit per channel, set while a flag is pending.
// - Only channels with mask bit one raise the host channel flag.
// - Reset, enable change or connect flag raises the port event flag.
// - Rate field reports 01 for full speed and 10 for low speed.
// - Power bit only records port power; no supply is driven.
// - Line state field: bit 10 positive line, bit 11 negative line.
// - Bus reset signalling is driven while the bus reset bit is set.
// - Sleep request suspends the port and stops frame start tokens.
// - Sleep clears only on bus reset, resume, wakeup or disconnect.
// - Resume signalling is driven while the resume bit is set.
// - Enabled bit changes set the enable change flag; write one clears.
// - Enabled bit sets when bus reset ends; software cannot set it.
// - Enabled bit clears on disconnect or on a software write of one.
// - Connect event flag sets on attach; write one clears it.
// - Connect state bit reads one while a device is attached.
// - Channel flags set by hardware, cleared only by writing one.
`timescale 1ns/1ps
`include "usb_port_params.svh"

module usb_host_port
    import usb_port_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Channel engine events, one nibble per channel
    input wire logic [31:0] chan_event_in,
    // Line side
    input wire logic line_dp_in,
    input wire logic line_dm_in,
    input wire logic attached_in,
    input wire logic low_speed_in,
    input wire logic wakeup_in,
    // Port control outputs
    output logic bus_reset_drive_out,
    output logic resume_drive_out,
    output logic frame_tokens_on_out,
    // Global flag outputs
    output logic host_channel_flag_out,
    output logic port_event_flag_out
);
    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire logic access = psel_in && penable_in;
    wire logic wr = access && pwrite_in;
    wire logic sel_sum = (paddr_in == `OFF_CHAN_SUMMARY);
    wire logic sel_mask = (paddr_in == `OFF_CHAN_MASK);
    wire logic sel_pcs = (paddr_in == `OFF_PORT_CS);
    wire logic sel_flags = (paddr_in == `OFF_CHAN_FLAGS);
    wire logic mapped = sel_sum | sel_mask | sel_pcs | sel_flags;
    wire logic wr_mask = wr && sel_mask;
    wire logic wr_pcs = wr && sel_pcs;
    wire logic wr_flags = wr && sel_flags;

    // ------------------------------------------------------------
    // Channel flags and summary
    // ------------------------------------------------------------
    logic [31:0] chan_flags;
    logic [7:0] chan_pending;
    logic [7:0] chan_mask_q;

    genvar g;
    generate
        for (g = 0; g < `NUM_CHANNELS; g++) begin : g_chan
            chan_flag_cell u_cell (
                .clk_in(clk_in),
                .reset_n_in(reset_n_in),
                .set_in(chan_event_in[g*4 +: 4]),
                .clear_in(wr_flags ? pwdata_in[g*4 +: 4] : 4'h0),
                .flags_out(chan_flags[g*4 +: 4]),
                .pending_out(chan_pending[g])
            );
        end
    endgenerate

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            chan_mask_q <= `CHAN_MASK_RESET;
        end else if (wr_mask) begin
            chan_mask_q <= pwdata_in[7:0];
        end
    end

    wire logic host_flag_d = |(chan_pending & chan_mask_q);

    // ------------------------------------------------------------
    // Line sampling
    // ------------------------------------------------------------
    logic [2:0] line_sync;

    line_sampler u_sampler (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .raw_in({attached_in, line_dm_in, line_dp_in}),
        .sync_out(line_sync)
    );

    logic attached_q;
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            attached_q <= 1'b0;
        end else begin
            attached_q <= line_sync[2];
        end
    end

    wire logic attach_evt = line_sync[2] && !attached_q;
    wire logic detach_evt = !line_sync[2] && attached_q;

    // ------------------------------------------------------------
    // Port control/status
    // ------------------------------------------------------------
    logic power_q;
    logic bus_reset_q;
    logic sleep_q;
    logic resume_q;
    logic enabled_q;
    logic en_change_q;
    logic connect_evt_q;
    logic [1:0] rate_q;
    logic [1:0] line_q;

    wire logic set_reset_bit = wr_pcs && pwdata_in[`PCS_BUS_RESET];
    wire logic set_resume_bit = wr_pcs && pwdata_in[`PCS_RESUME];
    wire logic reset_done = bus_reset_q && wr_pcs &&
                            !pwdata_in[`PCS_BUS_RESET];
    wire logic sw_disable = wr_pcs && pwdata_in[`PCS_LINK_ENABLED];

    // Enabled bit: hardware set after reset, cleared on detach or W1C
    wire logic enabled_d = (reset_done && line_sync[2]) ? 1'b1
                         : (detach_evt || sw_disable) ? 1'b0
                         : enabled_q;
    wire logic en_changed = (enabled_d != enabled_q);

    // Sleep clears only on the four listed events
    wire logic sleep_clr = set_reset_bit || set_resume_bit ||
                           line_sync[2] && wakeup_in || detach_evt;
    wire logic sleep_d = (wr_pcs && pwdata_in[`PCS_SLEEP]) ? 1'b1
                       : sleep_clr ? 1'b0
                       : sleep_q;

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            power_q <= 1'b0;
            bus_reset_q <= 1'b0;
            sleep_q <= 1'b0;
            resume_q <= 1'b0;
            enabled_q <= 1'b0;
            en_change_q <= 1'b0;
            connect_evt_q <= 1'b0;
            rate_q <= RATE_NONE;
            line_q <= 2'h0;
        end else begin
            if (wr_pcs) begin
                power_q <= pwdata_in[`PCS_POWER];
                bus_reset_q <= pwdata_in[`PCS_BUS_RESET];
                resume_q <= pwdata_in[`PCS_RESUME];
            end
            sleep_q <= sleep_d;
            enabled_q <= enabled_d;
            // Hardware set wins over write-one clear
            en_change_q <= en_changed || (en_change_q &&
                !(wr_pcs && pwdata_in[`PCS_ENABLE_CHANGE]));
            connect_evt_q <= attach_evt || (connect_evt_q &&
                !(wr_pcs && pwdata_in[`PCS_CONNECT_EVENT]));
            line_q <= line_sync[1:0];
            if (reset_done) begin
                rate_q <= low_speed_in ? RATE_LOW : RATE_FULL;
            end else if (detach_evt) begin
                rate_q <= RATE_NONE;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    logic port_flag_q;
    logic host_flag_q;
    logic drive_reset_q;
    logic drive_resume_q;
    logic tokens_q;

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            port_flag_q <= 1'b0;
            host_flag_q <= 1'b0;
            drive_reset_q <= 1'b0;
            drive_resume_q <= 1'b0;
            tokens_q <= 1'b0;
        end else begin
            port_flag_q <= en_change_q || connect_evt_q ||
                           bus_reset_q;
            host_flag_q <= host_flag_d;
            drive_reset_q <= bus_reset_q;
            drive_resume_q <= resume_q;
            tokens_q <= enabled_q && !sleep_q;
        end
    end

    assign bus_reset_drive_out = drive_reset_q;
    assign resume_drive_out = drive_resume_q;
    assign frame_tokens_on_out = tokens_q;
    assign host_channel_flag_out = host_flag_q;
    assign port_event_flag_out = port_flag_q;

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    logic [31:0] pcs_view;
    always_comb begin
        pcs_view = 32'h0000_0000;
        pcs_view[`PCS_CONNECT_STATE] = attached_q;
        pcs_view[`PCS_CONNECT_EVENT] = connect_evt_q;
        pcs_view[`PCS_LINK_ENABLED] = enabled_q;
        pcs_view[`PCS_ENABLE_CHANGE] = en_change_q;
        pcs_view[`PCS_RESUME] = resume_q;
        pcs_view[`PCS_SLEEP] = sleep_q;
        pcs_view[`PCS_BUS_RESET] = bus_reset_q;
        pcs_view[`PCS_LINE_HI:`PCS_LINE_LO] = line_q;
        pcs_view[`PCS_POWER] = power_q;
        pcs_view[`PCS_RATE_HI:`PCS_RATE_LO] = rate_q;
    end

    wire logic [31:0] rd_mux = sel_sum ? {24'h000000, chan_pending}
                             : sel_mask ? {24'h000000, chan_mask_q}
                             : sel_pcs ? pcs_view
                             : sel_flags ? chan_flags
                             : 32'h0000_0000;

    logic [31:0] prdata_q;
    logic pslverr_q;
    logic pready_q;
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
            pready_q <= 1'b0;
        end else begin
            pready_q <= 1'b1;
            prdata_q <= (psel_in && !penable_in) ? rd_mux : prdata_q;
            pslverr_q <= psel_in && !penable_in && !mapped;
        end
    end

    assign prdata_out = prdata_q;
    assign pslverr_out = pslverr_q;
    assign pready_out = pready_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_host_flag;
        @(posedge clk_in) disable iff (!reset_n_in)
        host_channel_flag_out == $past(host_flag_d);
    endproperty
    a_host_flag: assert property (p_host_flag)
        else $error("host channel flag not masked summary");

    property p_enable_not_by_sw;
        @(posedge clk_in) disable iff (!reset_n_in)
        $rose(enabled_q) |-> $past(reset_done);
    endproperty
    a_enable_not_by_sw: assert property (p_enable_not_by_sw)
        else $error("enabled set without reset completion");

    property p_en_change;
        @(posedge clk_in) disable iff (!reset_n_in)
        (enabled_q != $past(enabled_q)) |-> en_change_q;
    endproperty
    a_en_change: assert property (p_en_change)
        else $error("enable change flag missed");

    property p_sleep_clear;
        @(posedge clk_in) disable iff (!reset_n_in)
        $fell(sleep_q) |-> $past(sleep_clr);
    endproperty
    a_sleep_clear: assert property (p_sleep_clear)
        else $error("sleep request cleared without cause");

    property p_tokens;
        @(posedge clk_in) disable iff (!reset_n_in)
        sleep_q |=> !frame_tokens_on_out;
    endproperty
    a_tokens: assert property (p_tokens)
        else $error("frame tokens while suspended");

    property p_reset_drive;
        @(posedge clk_in) disable iff (!reset_n_in)
        bus_reset_q |=> bus_reset_drive_out;
    endproperty
    a_reset_drive: assert property (p_reset_drive)
        else $error("bus reset not driven");

    property p_detach;
        @(posedge clk_in) disable iff (!reset_n_in)
        detach_evt |=> !enabled_q;
    endproperty
    a_detach: assert property (p_detach)
        else $error("enabled survives detach");

    property p_port_event;
        @(posedge clk_in) disable iff (!reset_n_in)
        $rose(connect_evt_q) |=> port_event_flag_out;
    endproperty
    a_port_event: assert property (p_port_event)
        else $error("port event flag missed connect");
endmodule : usb_host_port

// ---- bench/usb_device_model.sv ----
`timescale 1ns/1ps

// ------------------------------------------------------------
// Attached device: line levels and attach state
// ------------------------------------------------------------
module usb_device_model (
    // Scenario commands
    input wire logic attach_in,
    input wire logic low_in,
    input wire logic wake_in,
    // Host drive levels
    input wire logic bus_reset_in,
    input wire logic resume_in,
    // Line side
    output logic dp_out,
    output logic dm_out,
    output logic attached_out,
    output logic low_speed_out,
    output logic wakeup_out
);
    logic se0;
    logic kst;
    // Host forces SE0 in reset, K in resume; pull-downs when detached
    assign se0 = bus_reset_in || !attach_in;
    assign kst = resume_in;
    assign dp_out = !se0 && (low_in ^ !kst);
    assign dm_out = !se0 && !(low_in ^ !kst);
    assign attached_out = attach_in;
    assign low_speed_out = low_in;
    assign wakeup_out = wake_in && attach_in;
endmodule : usb_device_model

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
`include "usb_port_params.svh"

module testbench;
    logic clk_in, reset_n_in, psel, pen, pwr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata_v, chan_ev;
    logic pready, pslverr, err_v, dp, dm, att, lsp, wak;
    logic brst, resm, sof, hcf, pef, p_att, p_low, p_wake;
    int miscompares = 0;
    int n_checks = 0;

    usb_host_port usb_host_port_inst (.clk_in(clk_in),
        .reset_n_in(reset_n_in), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .chan_event_in(chan_ev), .line_dp_in(dp), .line_dm_in(dm),
        .attached_in(att), .low_speed_in(lsp), .wakeup_in(wak),
        .bus_reset_drive_out(brst), .resume_drive_out(resm),
        .frame_tokens_on_out(sof), .host_channel_flag_out(hcf),
        .port_event_flag_out(pef));

    usb_device_model usb_device_model_inst (.attach_in(p_att),
        .low_in(p_low), .wake_in(p_wake), .bus_reset_in(brst),
        .resume_in(resm), .dp_out(dp), .dm_out(dm), .attached_out(att),
        .low_speed_out(lsp), .wakeup_out(wak));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] s, e);
        n_checks++;
        if (s !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask : tick

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        pen <= 1'b1;
        do begin
            @(posedge clk_in);
        end while (pready !== 1'b1);
        rdata_v = prdata;
        err_v = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk_in);
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), rdata_v, e);
    endtask : rd

    task automatic give_verdict();
        if (miscompares == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : give_verdict

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        rd(`OFF_CHAN_MASK, 32'h0);
        rd(`OFF_PORT_CS, 32'h0);
        rd(`OFF_CHAN_SUMMARY, 32'h0);
        rd(12'h7FC, 32'h0);
        chk("slverr", {31'h0, err_v}, 32'h1);
        apb(1'b1, `OFF_CHAN_MASK, 32'h0000_0005);
        rd(`OFF_CHAN_MASK, 32'h0000_0005);
    endtask : t_regs

    task automatic t_chan();
        chan_ev <= 32'h0000_0040;
        tick(1);
        chan_ev <= 32'h0;
        tick(3);
        rd(`OFF_CHAN_SUMMARY, 32'h0000_0002);
        chk("hcf masked", {31'h0, hcf}, 32'h0);
        chan_ev <= 32'h0000_0100;
        tick(1);
        chan_ev <= 32'h0;
        tick(3);
        rd(`OFF_CHAN_SUMMARY, 32'h0000_0006);
        chk("hcf", {31'h0, hcf}, 32'h1);
        apb(1'b1, `OFF_CHAN_FLAGS, 32'h0);
        rd(`OFF_CHAN_FLAGS, 32'h0000_0140);
        apb(1'b1, `OFF_CHAN_FLAGS, 32'h0000_0100);
        tick(2);
        rd(`OFF_CHAN_SUMMARY, 32'h0000_0002);
        chk("hcf off", {31'h0, hcf}, 32'h0);
        apb(1'b1, `OFF_CHAN_FLAGS, 32'h0000_0040);
        rd(`OFF_CHAN_SUMMARY, 32'h0);
    endtask : t_chan

    task automatic t_enum(input logic low);
        logic [31:0] idl, rt;
        idl = low ? 32'h800 : 32'h400;
        rt = low ? 32'h40000 : 32'h20000;
        apb(1'b1, `OFF_PORT_CS, 32'h1000);
        p_att <= 1'b1;
        p_low <= low;
        tick(5);
        rd(`OFF_PORT_CS, 32'h1003 | idl);
        chk("pef attach", {31'h0, pef}, 32'h1);
        apb(1'b1, `OFF_PORT_CS, 32'h1006);
        rd(`OFF_PORT_CS, 32'h1001 | idl);
        apb(1'b1, `OFF_PORT_CS, 32'h1100);
        tick(4);
        chk("reset drive", {31'h0, brst}, 32'h1);
        chk("pef reset", {31'h0, pef}, 32'h1);
        rd(`OFF_PORT_CS, 32'h1101);
        apb(1'b1, `OFF_PORT_CS, 32'h1000);
        tick(3);
        chk("reset off", {31'h0, brst}, 32'h0);
        rd(`OFF_PORT_CS, 32'h100D | idl | rt);
        apb(1'b1, `OFF_PORT_CS, 32'h1008);
        rd(`OFF_PORT_CS, 32'h1005 | idl | rt);
        if (low) begin
            apb(1'b1, `OFF_PORT_CS, 32'h1004);
            rd(`OFF_PORT_CS, 32'h1009 | idl | rt);
            apb(1'b1, `OFF_PORT_CS, 32'h1008);
            p_att <= 1'b0;
            tick(5);
            rd(`OFF_PORT_CS, 32'h1000);
        end
    endtask : t_enum

    task automatic t_sleep();
        chk("sof on", {31'h0, sof}, 32'h1);
        apb(1'b1, `OFF_PORT_CS, 32'h1080);
        tick(2);
        chk("sof off", {31'h0, sof}, 32'h0);
        apb(1'b1, `OFF_PORT_CS, 32'h1000);
        rd(`OFF_PORT_CS, 32'h2_1485);
        apb(1'b1, `OFF_PORT_CS, 32'h1040);
        tick(3);
        chk("resume drive", {31'h0, resm}, 32'h1);
        rd(`OFF_PORT_CS, 32'h2_1845);
        apb(1'b1, `OFF_PORT_CS, 32'h1000);
        tick(3);
        chk("resume off", {31'h0, resm}, 32'h0);
        chk("sof back", {31'h0, sof}, 32'h1);
        apb(1'b1, `OFF_PORT_CS, 32'h1080);
        p_wake <= 1'b1;
        tick(4);
        p_wake <= 1'b0;
        rd(`OFF_PORT_CS, 32'h2_1405);
        apb(1'b1, `OFF_PORT_CS, 32'h1080);
        apb(1'b1, `OFF_PORT_CS, 32'h1100);
        apb(1'b0, `OFF_PORT_CS, 32'h0);
        chk("sleep bit", rdata_v & 32'h80, 32'h0);
        apb(1'b1, `OFF_PORT_CS, 32'h1000);
        tick(3);
        apb(1'b1, `OFF_PORT_CS, 32'h1080);
        p_att <= 1'b0;
        tick(5);
        rd(`OFF_PORT_CS, 32'h1008);
        chk("pef detach", {31'h0, pef}, 32'h1);
    endtask : t_sleep

    // ------------------------------------------------------------
    // Clock, reset, sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end

    initial begin
        reset_n_in = 1'b0;
        {psel, pen, pwr, p_att, p_low, p_wake} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        chan_ev = 32'h0;
        tick(20);
        reset_n_in <= 1'b1;
        tick(1);
        t_regs();
        t_chan();
        t_enum(1'b1);
        t_enum(1'b0);
        t_sleep();
        give_verdict();
    end

    initial begin
        #400000;
        miscompares++;
        give_verdict();
    end
endmodule : testbench
